// [rx_order_pkg.sv]
// Purpose: shared constants for the receive byte deserializer and orderer
// Assumes: one clock domain, byte stream from the receive PCS
// Notes:   byte width 10 covers both 8-bit raw and 9-bit decoded bytes
package rx_order_pkg;
   localparam int BYTE_W      = 10;
   localparam int WORD_W      = 2 * BYTE_W;
   localparam int PAT_W       = 9;
   localparam int FIFO_DEPTH  = 16;
   localparam int CTRL_BIT    = 8;
   localparam logic [PAT_W-1:0] PAT_RESET = 9'h0_00;
   localparam logic [PAT_W-1:0] PAD_RESET = 9'h0_00;
endpackage

// [rx_order_fifo.sv]
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module rx_order_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign wr_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign rd_valid_out = wr_ptr != rd_ptr;
   assign push = wr_valid_in && wr_ready_out;
   assign pop  = rd_valid_out && rd_ready_in;
   assign rd_data_out = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// [rx_byte_deserializer_ordering.sv]
// Purpose: pair PCS bytes into double-width words and restore byte order
// Assumes: one byte per clock when byte_valid_in is high
// Notes:   words leave through a 16-word FIFO; stalls back-pressure bytes
`timescale 1ns/1ps
module rx_byte_deserializer_ordering
   import rx_order_pkg::*;
(
   input  wire logic                            clk_in,
   input  wire logic                            rst_n_in,
   input  wire logic                            byte_valid_in,
   output logic                                 byte_ready_out,
   input  wire logic [rx_order_pkg::BYTE_W-1:0] byte_in,
   input  wire logic                            ctrl_flag_in,
   input  wire logic                            wide_byte_in,
   input  wire logic                            dec_enable_in,
   input  wire logic                            align_auto_in,
   input  wire logic                            order_enable_in,
   input  wire logic [rx_order_pkg::PAT_W-1:0]  order_pattern_in,
   input  wire logic [rx_order_pkg::PAT_W-1:0]  pad_byte_in,
   output logic                                 word_valid_out,
   input  wire logic                            word_ready_in,
   output logic [rx_order_pkg::WORD_W-1:0]      word_out,
   output logic [1:0]                           word_ctrl_out,
   output logic                                 order_active_out,
   output logic                                 order_done_out,
   output logic                                 phase_out
);
   import rx_order_pkg::*;

   localparam int FW     = WORD_W + 2;
   localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;
   localparam logic [FILL_W-1:0] FULL = FILL_W'(FIFO_DEPTH);

   logic              phase;
   logic [BYTE_W-1:0] low_byte;
   logic              low_ctrl;
   logic              pair_valid;
   logic [BYTE_W-1:0] pair_hi;
   logic [BYTE_W-1:0] pair_lo;
   logic              pair_hi_c;
   logic              pair_lo_c;
   logic              done;
   logic              order_ok;
   logic              hit;
   logic              fifo_ready;
   logic              fifo_valid;
   logic [FW-1:0]     fifo_in;
   logic [FW-1:0]     fifo_q;
   logic              take;
   logic [BYTE_W-1:0] pad_val;
   logic              pad_c;
   logic              pad_go;
   logic              push_w;
   logic              pop_w;
   logic [FILL_W-1:0] fill;
   logic [1:0]        pads;

   // compare one byte against the pattern, masking to the active width
   function automatic logic byte_match(input logic [BYTE_W-1:0] b,
                                       input logic              c,
                                       input logic              dec,
                                       input logic [PAT_W-1:0]  pat);
      if (dec) begin
         return {c, b[7:0]} == pat;
      end
      return b[7:0] == pat[7:0];
   endfunction

   assign order_ok = order_enable_in && !wide_byte_in &&
                     (dec_enable_in == align_auto_in);

   assign take = byte_valid_in && byte_ready_out;
   // stall on pad, so no byte is lost in the slip
   assign byte_ready_out = (!pair_valid || fifo_ready) && !hit;

   assign hit = order_ok && !done && pair_valid &&
                byte_match(pair_hi, pair_hi_c, dec_enable_in,
                           order_pattern_in);

   assign pad_val = {2'b00, pad_byte_in[7:0]};
   assign pad_c   = dec_enable_in ? pad_byte_in[CTRL_BIT] : 1'b0;

   // pad insert
   // hit and take never meet, as the byte is stalled while the pad leaves
   assign pad_go = hit && fifo_ready;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         phase <= 1'b0;
      end else if (pad_go) begin
         phase <= 1'b1;
      end else if (take) begin
         phase <= !phase;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         low_byte <= '0;
         low_ctrl <= 1'b0;
      end else if (pad_go) begin
         // pattern byte moves to low half of the next word
         low_byte <= pair_hi;
         low_ctrl <= pair_hi_c;
      end else if (take && !phase) begin
         low_byte <= byte_in;
         low_ctrl <= ctrl_flag_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pair_lo   <= '0;
         pair_lo_c <= 1'b0;
         pair_hi   <= '0;
         pair_hi_c <= 1'b0;
      end else if (take && phase) begin
         pair_lo   <= low_byte;
         pair_lo_c <= low_ctrl;
         pair_hi   <= byte_in;
         pair_hi_c <= ctrl_flag_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pair_valid <= 1'b0;
      end else if (take && phase) begin
         pair_valid <= 1'b1;
      end else if (fifo_ready) begin
         pair_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         done <= 1'b0;
      end else if (!order_ok) begin
         done <= 1'b0;
      end else if (pad_go) begin
         done <= 1'b1;
      end
   end

   // assertion helpers: FIFO occupancy and pads since enable
   assign push_w = pair_valid && fifo_ready;
   assign pop_w  = fifo_valid && word_ready_in;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fill <= '0;
      end else if (push_w && !pop_w) begin
         fill <= fill + 1'b1;
      end else if (!push_w && pop_w) begin
         fill <= fill - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !order_ok) begin
         pads <= '0;
      end else if (pad_go && pads != 2'h3) begin
         pads <= pads + 1'b1;
      end
   end

   assign fifo_in = hit ? {pad_c, pair_lo_c, pad_val, pair_lo}
                        : {pair_hi_c, pair_lo_c, pair_hi, pair_lo};

   rx_order_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .wr_valid_in  (pair_valid),
      .wr_ready_out (fifo_ready),
      .wr_data_in   (fifo_in),
      .rd_valid_out (fifo_valid),
      .rd_ready_in  (word_ready_in),
      .rd_data_out  (fifo_q)
   );

   assign word_valid_out   = fifo_valid;
   assign word_out         = fifo_q[WORD_W-1:0];
   assign word_ctrl_out    = fifo_q[FW-1:WORD_W];
   assign order_active_out = order_ok;
   assign order_done_out   = done;
   assign phase_out        = phase;

   pad_once_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      pad_go |=> done && !hit)
      else $error("pad inserted more than once");
   pad_value_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      hit |-> fifo_in[2*BYTE_W-1:BYTE_W] == {2'h0, pad_byte_in[7:0]})
      else $error("pad byte not in upper half");
   low_keep_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      hit |-> fifo_in[BYTE_W-1:0] == pair_lo && fifo_in[FW-2] == pair_lo_c)
      else $error("low byte lost at pad");
   pad_count_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      pads < 2'h2)
      else $error("more than one pad since enable");

   shift_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      pad_go |=> low_byte == $past(pair_hi) && phase)
      else $error("pattern not moved to low position");
   pad_stall_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      hit |-> !byte_ready_out)
      else $error("byte accepted while pad goes out");

   pair_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && phase) |=> pair_valid && pair_hi == $past(byte_in) &&
                          pair_lo == $past(low_byte))
      else $error("bytes not paired");
   toggle_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      take |=> phase != $past(phase))
      else $error("pairing phase did not advance");
   full_ready_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      fifo_ready == (fill != FULL))
      else $error("fifo ready disagrees with fill");
   half_rate_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (take && !phase) |=> !pair_valid)
      else $error("word produced on first byte");
   fill_bound_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      fill <= FULL)
      else $error("fifo fill beyond depth");
   empty_valid_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      word_valid_out == (fill != '0))
      else $error("word valid disagrees with fill");
   word_hold_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (word_valid_out && !word_ready_in) |=>
         word_valid_out && $stable(word_out) && $stable(word_ctrl_out))
      else $error("stalled word changed");

   raw_search_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (order_ok && !done && pair_valid && !dec_enable_in &&
       pair_hi[7:0] == order_pattern_in[7:0]) |-> hit)
      else $error("raw pattern in upper byte missed");
   dec_search_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (order_ok && !done && pair_valid && dec_enable_in &&
       {pair_hi_c, pair_hi[7:0]} == order_pattern_in) |-> hit)
      else $error("decoded pattern in upper byte missed");
   dec_flag_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (dec_enable_in && pair_hi_c != order_pattern_in[CTRL_BIT]) |-> !hit)
      else $error("match ignored control flag");
   flag_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (hit && dec_enable_in) |-> fifo_in[FW-1] == pad_byte_in[CTRL_BIT])
      else $error("control flag of pad wrong");
   ctrl_pad_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (hit && !dec_enable_in) |-> !fifo_in[FW-1])
      else $error("raw pad carries control flag");

   mode_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !order_ok |-> !hit)
      else $error("ordering in unsupported mode");
   done_clear_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !order_ok |=> !done)
      else $error("done kept in unsupported mode");
   wide_off_a: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wide_byte_in |-> !order_active_out)
      else $error("ordering active with wide bytes");

   reset_phase_a: assert property (
      @(posedge clk_in)
      !rst_n_in |=> !phase && !pair_valid && !done)
      else $error("phase not cleared by reset");
   ready_reset_a: assert property (
      @(posedge clk_in)
      !rst_n_in |=> byte_ready_out && !word_valid_out)
      else $error("ready or valid wrong after reset");
endmodule

// [word_sink.sv]
// Purpose: fabric-side word sink with stall control
// Assumes: words pass when valid and ready meet at clk_in
// Notes:   ready is the inverse of stall_in one clock late, and is held low in reset
`timescale 1ns/1ps
module word_sink (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic stall_in,
   output logic      ready_out
);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= !stall_in;
      end
   end
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the byte deserializer and orderer
// Assumes: sink model stalls at random, bytes driven on falling edge
// Notes:   each test starts from a fresh reset, so pairing starts at 0
`timescale 1ns/1ps
module testbench;
   import rx_order_pkg::*;
   logic clk_in, rst_n_in, bv, br, cf, wide, dec, aut, oen, stall, wr, wv;
   logic act, done, phase, hold, seen;
   logic [BYTE_W-1:0] bd;
   logic [PAT_W-1:0]  pat, pad;
   logic [WORD_W-1:0] word;
   logic [1:0]        wc;
   logic [21:0]       got[$];
   logic [7:0]        bs[40];
   logic [15:0]       seed = 16'hBBC6;
   logic [15:0]       rs = 16'hBBC6;
   int                miscompares = 0;
   int                compares = 0;
   rx_byte_deserializer_ordering u_rx_byte_deserializer_ordering (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .byte_valid_in(bv),
      .byte_ready_out(br), .byte_in(bd), .ctrl_flag_in(cf),
      .wide_byte_in(wide), .dec_enable_in(dec), .align_auto_in(aut),
      .order_enable_in(oen), .order_pattern_in(pat), .pad_byte_in(pad),
      .word_valid_out(wv), .word_ready_in(wr), .word_out(word),
      .word_ctrl_out(wc), .order_active_out(act),
      .order_done_out(done), .phase_out(phase));
   word_sink u_word_sink (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .stall_in(stall), .ready_out(wr));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [21:0] pack_w(input logic [1:0] c,
                                          input logic [9:0] h,
                                          input logic [9:0] l);
      return {c, h, l};
   endfunction
   task automatic chk_w(input string nm, input logic [21:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_b(input string nm, input logic e, g);
      chk_w(nm, {21'd0, e}, {21'd0, g});
   endtask
   task automatic restart(input logic w, d, a, o);
      @(negedge clk_in);
      {wide, dec, aut, oen, rst_n_in, bv} = {w, d, a, o, 2'b00};
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      got.delete();
   endtask
   task automatic send(input logic [9:0] b, input logic f);
      int n;
      @(negedge clk_in);
      {bv, bd, cf} = {1'b1, b, f};
      n = 0;
      // ready is settled at the falling edge; the byte goes at the next rise
      while (!br && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 300) miscompares++;
      @(posedge clk_in);
   endtask
   task automatic finish_words(input int k);
      @(negedge clk_in);
      bv = 1'b0;
      for (int n = 0; n < 300 && got.size() < k; n++) @(posedge clk_in);
      chk_b("word count", 1'b1, got.size() >= k);
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = !clk_in;
   end
   always @(negedge clk_in) begin
      stall <= hold | rs[0];
      rs <= lfsr(rs);
   end
   always @(posedge clk_in) begin
      if (rst_n_in && wv && wr) got.push_back({wc, word});
      if (bv && !br) seen <= 1'b1;
   end
   initial begin
      #100000;
      miscompares++;
      complete_run();
   end
   initial begin
      {rst_n_in, bv, bd, cf, pat, pad, hold, seen} = '0;
      {wide, dec, aut, oen} = 4'b0000;
      restart(0, 0, 0, 0);
      hold = 1'b1;
      for (int i = 0; i < 40; i++) begin
         bs[i] = seed[7:0];
         seed = lfsr(seed);
      end
      fork
         for (int i = 0; i < 40; i++) send({2'b00, bs[i]}, 1'b0);
         begin
            repeat (60) @(posedge clk_in);
            hold = 1'b0;
         end
      join
      finish_words(20);
      chk_b("stall", 1'b1, seen);
      for (int i = 0; i < 20; i++)
         chk_w("word", pack_w(2'h0, {2'h0, bs[2*i+1]}, {2'h0, bs[2*i]}),
               got[i]);
      $display("test pass-through done");
      {pat, pad} = {9'h0_A5, 9'h0_3C};
      restart(0, 0, 0, 1);
      chk_b("active", 1'b1, act);
      // pattern sent in the low slot and passed, then sent in the high slot and slipped to the low slot
      send(10'h0A5, 1'b0);
      send(10'h066, 1'b0);
      send(10'h011, 1'b0);
      send(10'h0A5, 1'b0);
      send(10'h022, 1'b0);
      send(10'h033, 1'b0);
      finish_words(3);
      chk_w("low hit", 22'h01_98A5, got[0]);
      chk_w("pad", 22'h00_F011, got[1]);
      chk_w("shift", 22'h00_88A5, got[2]);
      chk_b("phase", 1'b1, phase);
      chk_b("done", 1'b1, done);
      $display("test raw ordering done");
      {pat, pad} = {9'h1_BC, 9'h1_F7};
      restart(0, 1, 1, 1);
      send(10'h011, 1'b0);
      send(10'h0BC, 1'b0);
      send(10'h022, 1'b0);
      send(10'h0BC, 1'b1);
      send(10'h033, 1'b0);
      finish_words(3);
      chk_w("no flag", 22'h02_F011, got[0]);
      chk_w("pad9", 22'h23_DC22, got[1]);
      chk_w("flag lo", 22'h10_CCBC, got[2]);
      chk_b("phase dec", 1'b0, phase);
      $display("test decoded ordering done");
      for (int c = 0; c < 3; c++) begin
         restart(c == 0, c == 1, c == 2, 1'b1);
         chk_b("inactive", 1'b0, act);
         send(c == 0 ? 10'h355 : 10'h055, 1'b0);
         send(c == 0 ? 10'h2BC : 10'h0BC, 1'b0);
         finish_words(1);
         chk_w("plain", c == 0 ? 22'h0A_F355 : 22'h02_F055,
               got[0]);
      end
      $display("test illegal modes done");
      complete_run();
   end
endmodule
